// ==== rtl/snap_pkg.sv ====
// Constants for the time snapshot register window
// Notes on behaviour
// R1: Decode sixteen byte addresses; registers eight bits.
// R2: Two banks; bank select at F always.
// R3: Bit 0 picks bank; others ignored.
// R4: Reset clears bank select and snapshot bytes.
// R5: Request read copies time and status.
// R6: No capture while time counter updates.
// R7: Snapshot valid on next host read.
// R8: Snapshot held until next request read.
// R9: Snapshot bytes at bank zero offsets 1-8.
// R10: Digits are four-bit BCD, two per byte.
// R11: High digit upper nibble; byte 1 status.
// R12: Bit 4 set while flywheeling.
// R13: Bit 5 set when outside sync window.
// R14: Bit 6 set when stability out of limit.
// R15: Bit 7 unused; write ignored, read undefined.
// R16: Host writes zero to unused bits; the bench writes 8'hff to bank select at F.
// R17: Mode codes zero to four.
// R18: Offsets 9-E unused, no side effects.
// R19: Bank zero side effects only in bank zero.
package snap_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SNAP_BYTES = 8;
    localparam int TIME_DIGITS = 15;
    localparam logic [3:0] OFF_REQUEST = 4'h0;
    localparam logic [3:0] OFF_SNAP_FIRST = 4'h1;
    localparam logic [3:0] OFF_SNAP_LAST = 4'h8;
    localparam logic [3:0] OFF_BANK_SELECT = 4'hf;
    localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
    localparam logic [7:0] SNAP_RESET = 8'h00;
    localparam logic [7:0] UNDEF_READ = 8'h00;
    localparam int BANK_BIT = 0;
    localparam int ST_FLYWHEEL = 4;
    localparam int ST_UNSYNC = 5;
    localparam int ST_UNSTABLE = 6;
    localparam int ST_UNUSED = 7;
    localparam logic [2:0] MODE_DECODER = 3'h0;
    localparam logic [2:0] MODE_FREE_RUN = 3'h1;
    localparam logic [2:0] MODE_EXT_PPS = 3'h2;
    localparam logic [2:0] MODE_BATTERY = 3'h3;
    localparam logic [2:0] MODE_SATELLITE = 3'h4;
    localparam logic [3:0] SYNC_LIMIT_DECODER_US = 4'h5;
    localparam logic [3:0] SYNC_LIMIT_OTHER_US = 4'h2;
    localparam logic [3:0] STAB_EXP_DECODER = 4'h7;
    localparam logic [3:0] STAB_EXP_OTHER = 4'h8;
endpackage

// ==== rtl/snap_status.sv ====
// Tracking status nibble built from reference presence, measured error and stability
`timescale 1ns/10ps
`default_nettype none
module snap_status
    import snap_pkg::*;
(
    input wire logic [2:0] mode_i,
    input wire logic ref_present_i,
    input wire logic [15:0] time_err_us_i,
    input wire logic [3:0] stab_exp_i,
    output logic [3:0] status_o
);
    logic [3:0] sync_limit;
    logic [3:0] stab_limit;
    always_comb begin
        // Mode decides both thresholds
        sync_limit = (mode_i == MODE_DECODER) ? SYNC_LIMIT_DECODER_US : SYNC_LIMIT_OTHER_US; // R17
        stab_limit = (mode_i == MODE_DECODER) ? STAB_EXP_DECODER : STAB_EXP_OTHER; // R17
        status_o = 4'h0;
        status_o[ST_FLYWHEEL - 4] = ~ref_present_i; // R12
        status_o[ST_UNSYNC - 4] = time_err_us_i > {12'h000, sync_limit}; // R13
        // Stability given as exponent of 5e-X; smaller X is worse
        status_o[ST_UNSTABLE - 4] = stab_exp_i < stab_limit; // R14
        status_o[ST_UNUSED - 4] = 1'b0; // R15
    end
endmodule // snap_status
`default_nettype wire

// ==== rtl/time_snapshot_registers.sv ====
// Host register window with bank select and zero-latency time snapshot
`timescale 1ns/10ps
`default_nettype none
module time_snapshot_registers
    import snap_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [TIME_DIGITS*4-1:0] time_bcd_i,
    input wire logic time_updating_i,
    input wire logic [2:0] mode_i,
    input wire logic ref_present_i,
    input wire logic [15:0] time_err_us_i,
    input wire logic [3:0] stab_exp_i,
    output logic bank_o
);
    logic bank;
    logic next_bank;
    logic [DATA_W-1:0] snap [SNAP_BYTES];
    logic [DATA_W-1:0] next_snap [SNAP_BYTES];
    logic [TIME_DIGITS*4-1:0] stable_time;
    logic [TIME_DIGITS*4-1:0] next_stable_time;
    logic [3:0] stable_status;
    logic [3:0] next_stable_status;
    logic [3:0] status_now;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic req_read;

    snap_status u_status (
        .mode_i(mode_i),
        .ref_present_i(ref_present_i),
        .time_err_us_i(time_err_us_i),
        .stab_exp_i(stab_exp_i),
        .status_o(status_now)
    );

    // Time counter shadow: follows the counter only when it is settled,
    // so a capture never sees digits mid-carry
    always_comb begin
        next_stable_time = time_updating_i ? stable_time : time_bcd_i; // R6
        next_stable_status = time_updating_i ? stable_status : status_now; // R6
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            stable_time <= '0;
            stable_status <= 4'h0;
        end else begin
            stable_time <= next_stable_time;
            stable_status <= next_stable_status;
        end
    end

    // Request read only counts in bank zero
    assign req_read = rd_i && (addr_i == OFF_REQUEST) && !bank; // R5 R19

    always_comb begin
        next_bank = bank;
        if (wr_i && addr_i == OFF_BANK_SELECT) begin
            next_bank = wdata_i[BANK_BIT]; // R2 R3
        end
    end

    // Snapshot: status nibble high then fifteen digits, two per byte
    always_comb begin
        for (int i = 0; i < SNAP_BYTES; i++) begin
            next_snap[i] = snap[i]; // R8
        end
        if (req_read) begin
            next_snap[0] = {stable_status, stable_time[TIME_DIGITS*4-1 -: 4]}; // R5 R11
            for (int i = 1; i < SNAP_BYTES; i++) begin
                next_snap[i] = stable_time[(SNAP_BYTES-i)*8-1 -: 8]; // R9 R10 R11
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            bank <= BANK_SELECT_RESET[BANK_BIT]; // R4
            for (int i = 0; i < SNAP_BYTES; i++) begin
                snap[i] <= SNAP_RESET; // R4
            end
        end else begin
            bank <= next_bank;
            for (int i = 0; i < SNAP_BYTES; i++) begin
                snap[i] <= next_snap[i];
            end
        end
    end

    // Read data registered one cycle after the strobe; a read following a
    // request already sees the fresh snapshot
    always_comb begin
        next_rdata = UNDEF_READ; // R18
        if (rd_i) begin
            if (addr_i == OFF_BANK_SELECT) begin
                next_rdata = {7'h00, bank}; // R2 R3
            end else if (!bank && addr_i >= OFF_SNAP_FIRST && addr_i <= OFF_SNAP_LAST) begin
                next_rdata = snap[3'(addr_i - OFF_SNAP_FIRST)]; // R7 R9
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata <= UNDEF_READ;
        end else begin
            rdata <= next_rdata; // R1
        end
    end

    assign rdata_o = rdata;
    assign bank_o = bank;

    sequence s_request;
        rd_i && addr_i == OFF_REQUEST && !bank;
    endsequence

    a_bank_write: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R3
        wr_i && addr_i == OFF_BANK_SELECT |=> bank == $past(wdata_i[BANK_BIT]))
        else $error("bank select not written");
    a_snap_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R8
        !req_read |=> snap[3] == $past(snap[3]))
        else $error("snapshot changed without request");
    a_snap_load: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R5
        s_request |=> snap[SNAP_BYTES-1] == $past(stable_time[7:0]))
        else $error("snapshot not loaded");
    a_no_tear: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R6
        time_updating_i |=> stable_time == $past(stable_time))
        else $error("shadow changed during update");
    a_zero_latency: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R7
        s_request ##1 (rd_i && addr_i == OFF_SNAP_LAST && !bank)
        |=> rdata_o == $past(stable_time[7:0], 2))
        else $error("snapshot not valid on next read");
    a_bank_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R19
        bank && rd_i |=> $stable(snap[0]))
        else $error("bank one read touched snapshot");
    a_unused_read: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R18
        rd_i && addr_i > OFF_SNAP_LAST && addr_i != OFF_BANK_SELECT |=> rdata_o == UNDEF_READ)
        else $error("unused offset returned data");
    a_bank_read: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R2
        rd_i && addr_i == OFF_BANK_SELECT |=> rdata_o == {7'h00, $past(bank)})
        else $error("bank select read wrong");
    a_status_nib: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R12
        s_request |=> snap[0][ST_FLYWHEEL] == $past(stable_status[0]))
        else $error("status nibble misplaced");

    // Further bank and read-path steps
    sequence s_bank_write;
        wr_i && addr_i == OFF_BANK_SELECT;
    endsequence

    sequence s_bank_read;
        rd_i && addr_i == OFF_BANK_SELECT;
    endsequence

    sequence s_unused_read;
        rd_i && addr_i > OFF_SNAP_LAST && addr_i != OFF_BANK_SELECT;
    endsequence

    sequence s_bank1_read;
        rd_i && bank && addr_i != OFF_BANK_SELECT;
    endsequence

    sequence s_snap_read;
        rd_i && !bank && addr_i >= OFF_SNAP_FIRST && addr_i <= OFF_SNAP_LAST;
    endsequence

    // Reset is checked outside the disable so the cleared state is seen
    a_reset_clear: assert property (@(posedge mclk_i) // R4
        !rstn_i |=> !bank && rdata_o == UNDEF_READ && snap[0] == SNAP_RESET && stable_time == '0)
        else $error("reset did not clear state");

    // Each packed byte holds two digits, upper digit high
    for (genvar g = 1; g < SNAP_BYTES; g++) begin : g_byte_chk
        a_byte_load: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R9 R10
            s_request |=> snap[g] == $past(stable_time[(SNAP_BYTES-g)*8-1 -: 8]))
            else $error("snapshot byte loaded wrong");

        a_byte_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R8
            !req_read |=> $stable(snap[g]))
            else $error("snapshot byte changed without request");
    end

    a_days_hund: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R11
        s_request |=> snap[0][3:0] == $past(stable_time[TIME_DIGITS*4-1 -: 4]))
        else $error("days hundreds digit misplaced");

    a_status_sync: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R13
        s_request |=> snap[0][ST_UNSYNC] == $past(stable_status[ST_UNSYNC-4]))
        else $error("sync bit misplaced");

    a_status_stab: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R14
        s_request |=> snap[0][ST_UNSTABLE] == $past(stable_status[ST_UNSTABLE-4]))
        else $error("stability bit misplaced");

    a_status_spare: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R15
        s_request |=> !snap[0][ST_UNUSED])
        else $error("spare status bit set");

    a_flywheel_now: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R12
        status_now[ST_FLYWHEEL-4] == !ref_present_i)
        else $error("flywheel bit wrong");

    // Thresholds: equal to the limit still counts as in sync
    a_sync_decoder: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R13 R17
        mode_i == MODE_DECODER && time_err_us_i <= 16'(SYNC_LIMIT_DECODER_US)
        |-> !status_now[ST_UNSYNC-4])
        else $error("decoder sync limit wrong");

    a_sync_other: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R13 R17
        mode_i != MODE_DECODER && time_err_us_i > 16'(SYNC_LIMIT_OTHER_US)
        |-> status_now[ST_UNSYNC-4])
        else $error("other sync limit wrong");

    a_stab_decoder: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R14 R17
        mode_i == MODE_DECODER && stab_exp_i >= STAB_EXP_DECODER |-> !status_now[ST_UNSTABLE-4])
        else $error("decoder stability limit wrong");

    a_stab_other: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R14 R17
        mode_i != MODE_DECODER && stab_exp_i < STAB_EXP_OTHER |-> status_now[ST_UNSTABLE-4])
        else $error("other stability limit wrong");

    // Shadow tracks the counter one cycle late while it is settled
    a_shadow_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R6
        !time_updating_i |=> stable_time == $past(time_bcd_i))
        else $error("shadow missed settled time");

    a_status_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R6
        !time_updating_i |=> stable_status == $past(status_now))
        else $error("shadow missed status");

    a_status_freeze: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R6
        time_updating_i |=> stable_status == $past(stable_status))
        else $error("status changed during update");

    a_bank_keep: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R3 R18
        !(wr_i && addr_i == OFF_BANK_SELECT) |=> $stable(bank))
        else $error("bank changed without write");

    a_bank_write_low: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R3
        s_bank_write |=> bank == $past(wdata_i[BANK_BIT]))
        else $error("bank bit taken from wrong place");

    a_bank_high_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R3
        s_bank_read |=> rdata_o[DATA_W-1:1] == '0)
        else $error("bank select upper bits not zero");

    a_unused_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R18
        s_unused_read |=> $stable(snap[0]) && $stable(bank))
        else $error("unused read had side effect");

    a_bank1_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R19
        s_bank1_read |=> rdata_o == UNDEF_READ)
        else $error("bank zero data seen in bank one");

    a_bank1_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R19
        bank |=> $stable(snap[SNAP_BYTES-1]))
        else $error("snapshot changed in bank one");

    // Output stands one cycle only, so a stale byte never looks like data
    a_idle_read: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R18
        !rd_i |=> rdata_o == UNDEF_READ)
        else $error("read data held without read");

    a_req_data: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R5
        s_request |=> rdata_o == UNDEF_READ)
        else $error("request read returned data");

    a_snap_read: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R9
        s_snap_read |=> rdata_o == $past(snap[3'(addr_i - OFF_SNAP_FIRST)]))
        else $error("snapshot read wrong byte");

    a_write_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R8
        wr_i |=> $stable(snap[0]) && $stable(snap[SNAP_BYTES-1]))
        else $error("write touched snapshot");
endmodule // time_snapshot_registers
`default_nettype wire

// ==== tb/host_model.sv ====
// Host processor model issuing byte-wide I/O cycles
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic mclk_i,
    output logic [3:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 4'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Held from one falling edge to the next, so one rising edge takes it
    task xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        addr_o = a;
        rd_o = ~w;
        wr_o = w;
        wdata_o = d;
        @(negedge mclk_i);
        q = rdata_i;
    endtask
    // Released lines flip so a stale value never looks valid
    task idle;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
endmodule // host_model
`default_nettype wire

// ==== tb/time_snapshot_registers_tb.sv ====
// Self-checking bench for the time snapshot register window
`timescale 1ns/10ps
`default_nettype none
module time_snapshot_registers_tb;
    import snap_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] addr;
    logic rd, wr, bank;
    logic upd = 1'b0;
    logic refp = 1'b1;
    logic [7:0] wdata, rdata, q;
    logic [59:0] tb = '0;
    logic [2:0] mode = 3'h0;
    logic [15:0] err = 16'h0000;
    logic [3:0] stab = 4'h9;
    int num_errors = 0;
    int n_compared = 0;
    always #2.5 mclk_i = ~mclk_i;
    time_snapshot_registers uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr), .rd_i(rd),
        .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .time_bcd_i(tb), .time_updating_i(upd),
        .mode_i(mode), .ref_present_i(refp), .time_err_us_i(err), .stab_exp_i(stab),
        .bank_o(bank));
    host_model host (.mclk_i(mclk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata),
        .rdata_i(rdata));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    function logic [7:0] eb(int k, logic [3:0] st, logic [59:0] t);
        if (k == 1) return {st, t[59:56]};
        return t[55-8*(k-2) -: 8];
    endfunction
    task rd_at(input logic [3:0] a);
        host.xfer(1'b0, a, 8'h00, q);
    endtask
    task t_reset;
        for (int k = 1; k <= 8; k++) begin
            rd_at(k[3:0]);
            chk(q, 8'h00);
        end
        rd_at(OFF_BANK_SELECT);
        chk(q, 8'h00);
        host.idle;
        $display("reset test done");
    endtask
    task t_snap;
        @(negedge mclk_i);
        tb = 60'h123143546789012;
        refp = 1'b0;
        err = 16'h0006;
        stab = 4'h6;
        repeat (2) @(negedge mclk_i);
        rd_at(OFF_REQUEST);
        for (int k = 1; k <= 8; k++) begin
            rd_at(k[3:0]);
            chk(q, eb(k, 4'h7, tb));
        end
        host.idle;
        @(negedge mclk_i);
        chk(rdata, UNDEF_READ);
        $display("snapshot test done");
    endtask
    task t_update;
        @(negedge mclk_i);
        tb = 60'h99;
        repeat (2) @(negedge mclk_i);
        upd = 1'b1;
        tb = 60'h100;
        repeat (2) @(negedge mclk_i);
        rd_at(OFF_REQUEST);
        rd_at(4'h8);
        chk(q, 8'h99);
        upd = 1'b0;
        host.idle;
        repeat (3) @(negedge mclk_i);
        rd_at(4'h8);
        chk(q, 8'h99);
        rd_at(OFF_REQUEST);
        rd_at(4'h7);
        chk(q, 8'h01);
        host.idle;
        $display("update test done");
    endtask
    task t_status;
        for (int m = 0; m <= 4; m++) begin
            @(negedge mclk_i);
            mode = m[2:0];
            refp = 1'b1;
            err = 16'h0003;
            stab = 4'h7;
            repeat (2) @(negedge mclk_i);
            rd_at(OFF_REQUEST);
            rd_at(OFF_SNAP_FIRST);
            chk(q, {1'b0, m != 0, m != 0, 5'h00});
            host.idle;
        end
        $display("status test done");
    endtask
    task t_bank;
        @(negedge mclk_i);
        tb = 60'h55;
        host.xfer(1'b1, OFF_BANK_SELECT, 8'hff, q);
        rd_at(OFF_BANK_SELECT);
        chk(q, 8'h01);
        chk({7'h00, bank}, 8'h01);
        rd_at(OFF_REQUEST);
        host.xfer(1'b1, OFF_BANK_SELECT, 8'h00, q);
        host.xfer(1'b1, 4'h8, 8'haa, q);
        rd_at(4'h8);
        chk(q, 8'h00);
        for (int a = 9; a <= 14; a++) begin
            rd_at(a[3:0]);
            chk(q, 8'h00);
        end
        host.idle;
        $display("bank test done");
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Fixed-cycle steps only, so one long watchdog bounds the run
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        $display("BAD %0t watchdog", $time);
        stop_test;
    end
    initial begin
        repeat (6) @(negedge mclk_i);
        rstn_i = 1'b1;
        t_reset;
        t_snap;
        t_update;
        t_status;
        t_bank;
        stop_test;
    end
endmodule // time_snapshot_registers_tb
`default_nettype wire
